// ==== rtl/pscr_pkg.sv ====
// Purpose: shared constants and types for protection stage config routing
// Assumes: one 100 MHz clock, register port with 8-bit index addresses
// Notes: stage order is low phase, high phase, low earth, high earth
package pscr_pkg;
    // ------------------------------------------------------------
    // register map (word indices)
    // ------------------------------------------------------------
    localparam logic [7:0] PSCR_ADDR_FSW2 = 8'h00;
    localparam logic [7:0] PSCR_ADDR_BLK = 8'h01;
    localparam logic [7:0] PSCR_ADDR_STAT = 8'h02;
    localparam logic [7:0] PSCR_ADDR_IRQST = 8'h03;
    localparam logic [7:0] PSCR_ADDR_IRQMSK = 8'h04;
    localparam logic [7:0] PSCR_ADDR_CMD = 8'h05;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] PSCR_FSW2_RST = 8'h00;
    localparam logic [7:0] PSCR_BLK_RST = 8'h00;
    localparam logic [7:0] PSCR_MSK_RST = 8'h00;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int PSCR_F_HP_OOS = 4;
    localparam int PSCR_F_HE_OOS = 5;
    localparam int PSCR_F_AR1_HP = 6;
    localparam int PSCR_F_AR3_HE = 7;
    localparam int PSCR_B_BANK_EXT = 4;
    localparam int PSCR_C_BANK = 0;
    localparam int PSCR_C_RESET = 1;
    localparam int PSCR_STG_LP = 0;
    localparam int PSCR_STG_HP = 1;
    localparam int PSCR_STG_LE = 2;
    localparam int PSCR_STG_HE = 3;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } pscr_req_t;

    typedef enum logic [0:0] {
        PSCR_BANK_MAIN,
        PSCR_BANK_SECOND
    } pscr_bank_t;
endpackage : pscr_pkg

// ==== rtl/pscr_sync.sv ====
// Purpose: two-flop synchroniser for a vector of pin levels
// Assumes: inputs asynchronous to core_clk
// Notes: first stage read only by the second stage
`timescale 1ns/10ps
module pscr_sync #(
    parameter int W = 8
) (
    input wire logic core_clk, // clock
    input wire logic rst_b, // async reset
    input wire logic [W-1:0] d, // async input
    output logic [W-1:0] q // synchronised output
);
    logic [W-1:0] meta_r;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_r <= '0;
            q <= '0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule : pscr_sync

// ==== rtl/pscr_top.sv ====
// Purpose: configuration and routing for four protection stages
// Assumes: raw stage starts/operates arrive as async levels
// Notes: registers reached over a plain strobe port
//
// Overview of operation
// RL1: switch bit 0 gives auto-clearing start indication
// RL2: bits 1-4 select manual hold per stage
// RL3: bit 5 disables high phase stage, dashed display
// RL4: bit 6 disables high earth stage, dashed display
// RL5: bit 7 routes high phase start to AR1
// RL6: bit 7 clear keeps high phase off AR1/SS3
// RL7: AR1 and third signal output always identical
// RL8: bit 8 picks low/high earth start for AR3
// RL9: second function group resets to zero
// RL10: blocking bits 1-4 let block input inhibit stage
// RL11: blocking bits zero means nothing blocked
// RL12: bank bit 0 selects bank by serial command
// RL13: bank bit 1, input low gives main bank
// RL14: bank bit 1, input high gives second bank
// RL15: blocking group resets to zero
// RL16: blocked or disabled stage outputs stay inactive
// RL17: manual indication clears only on reset action; the code also clears it when its switch bit is written to 0
//
// Local design decisions: the register offsets and the strobed register port.
`timescale 1ns/10ps
module pscr_top
    import pscr_pkg::*;
(
    input wire logic core_clk, // 100 MHz clock
    input wire logic rst_b, // async reset, active low
    input wire logic [7:0] reg_addr, // register index
    input wire logic [7:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    output logic [7:0] reg_rdata, // read data, cycle after strobe
    input wire logic [3:0] stage_start_raw, // raw stage starts
    input wire logic [3:0] stage_operate_raw, // raw stage operates
    input wire logic external_block_input, // block/control pin
    input wire logic indication_reset, // manual reset pin
    output logic [3:0] stage_start, // gated starts
    output logic [3:0] stage_operate, // gated operates
    output logic [3:0] start_indication, // start indicators
    output logic [1:0] out_of_service_display, // dashed display hp, he
    output logic autoreclose_output_first, // auto-reclose output 1
    input wire logic signal_output_third_alt, // other source for SS3 path
    output logic signal_output_third, // signal output 3
    output logic autoreclose_output_third, // auto-reclose output 3
    output logic setting_bank, // 0 main, 1 second
    output logic irq // level interrupt
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] fsw2;
        logic [7:0] blk;
        logic [3:0] msk;
        logic [3:0] ist;
        logic serial_bank;
        logic [7:0] rdata;
        logic [3:0] start;
        logic [3:0] oper;
        logic [3:0] ind;
        logic [1:0] oos;
        logic ar1;
        logic ss3;
        logic ar3;
        logic bank;
        logic irq;
        logic rst_prev;
    } pscr_state_t;

    pscr_state_t st_r;
    pscr_state_t st_nxt;
    pscr_req_t req;
    logic [5:0] sync_q;
    logic [3:0] sr_start;
    logic [3:0] sr_oper;
    logic sr_blk;
    logic sr_rst;

    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    pscr_sync #(.W(8)) u_sync (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .d({signal_output_third_alt, indication_reset, external_block_input,
            stage_operate_raw, stage_start_raw[3]}),
        .q({sync_q[5], sr_rst, sr_blk, sr_oper, sync_q[0]})
    );
    pscr_sync #(.W(3)) u_sync_s (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .d(stage_start_raw[2:0]),
        .q(sr_start[2:0])
    );
    assign sr_start[3] = sync_q[0];
    assign sync_q[4:1] = 4'h0;

    function automatic logic is_addr(input logic [7:0] a, input logic [7:0] b);
        is_addr = (a == b);
    endfunction : is_addr

    logic [3:0] enable_v;
    logic [3:0] blocked_v;
    logic [3:0] live_start;
    logic [3:0] set_ev;

    always_comb begin
        st_nxt = st_r;
        // RL3 RL4 out of service
        enable_v = 4'hF;
        enable_v[PSCR_STG_HP] = ~st_r.fsw2[PSCR_F_HP_OOS];
        enable_v[PSCR_STG_HE] = ~st_r.fsw2[PSCR_F_HE_OOS];
        // RL10 RL11 blocking per stage
        blocked_v = st_r.blk[3:0] & {4{sr_blk}};
        // RL16 gate stage signals
        live_start = sr_start & enable_v & ~blocked_v;
        st_nxt.start = live_start;
        st_nxt.oper = sr_oper & enable_v & ~blocked_v;
        st_nxt.oos = {st_r.fsw2[PSCR_F_HE_OOS], st_r.fsw2[PSCR_F_HP_OOS]};
        st_nxt.rst_prev = sr_rst;
        // RL1 RL2 RL17 indication modes
        for (int i = 0; i < 4; i++) begin
            if (st_r.fsw2[i]) begin
                if (live_start[i]) begin
                    st_nxt.ind[i] = 1'b1;
                end else if (sr_rst && !st_r.rst_prev) begin
                    st_nxt.ind[i] = 1'b0;
                end
            end else begin
                st_nxt.ind[i] = live_start[i];
            end
        end
        // RL5 RL6 RL7 first auto-reclose and SS3 shared
        if (st_r.fsw2[PSCR_F_AR1_HP]) begin
            st_nxt.ar1 = live_start[PSCR_STG_HP];
        end else begin
            st_nxt.ar1 = sync_q[5];
        end
        st_nxt.ss3 = st_nxt.ar1;
        // RL8 third auto-reclose source
        st_nxt.ar3 = st_r.fsw2[PSCR_F_AR3_HE] ? live_start[PSCR_STG_HE]
                                              : live_start[PSCR_STG_LE];
        // RL12 RL13 RL14 bank selection
        if (st_r.blk[PSCR_B_BANK_EXT]) begin
            st_nxt.bank = sr_blk ? PSCR_BANK_SECOND : PSCR_BANK_MAIN;
        end else begin
            st_nxt.bank = st_r.serial_bank;
        end
        // interrupt events: start rising edges
        set_ev = live_start & ~st_r.start;
        // register writes
        if (req.wr) begin
            if (is_addr(req.addr, PSCR_ADDR_FSW2)) begin
                st_nxt.fsw2 = req.wdata;
            end
            if (is_addr(req.addr, PSCR_ADDR_BLK)) begin
                st_nxt.blk = req.wdata;
            end
            if (is_addr(req.addr, PSCR_ADDR_IRQMSK)) begin
                st_nxt.msk = req.wdata[3:0];
            end
            if (is_addr(req.addr, PSCR_ADDR_IRQST)) begin
                st_nxt.ist = st_r.ist & ~req.wdata[3:0];
            end
            if (is_addr(req.addr, PSCR_ADDR_CMD)) begin
                st_nxt.serial_bank = req.wdata[PSCR_C_BANK];
                if (req.wdata[PSCR_C_RESET]) begin
                    st_nxt.ind = st_nxt.ind & ~(st_r.fsw2[3:0] & ~live_start);
                end
            end
        end
        st_nxt.ist = st_nxt.ist | set_ev;
        st_nxt.irq = |(st_nxt.ist & st_nxt.msk);
        // register reads
        st_nxt.rdata = 8'h00;
        if (req.rd) begin
            case (req.addr)
                PSCR_ADDR_FSW2: st_nxt.rdata = st_r.fsw2;
                PSCR_ADDR_BLK: st_nxt.rdata = st_r.blk;
                PSCR_ADDR_STAT: st_nxt.rdata = {st_r.bank, st_r.oos, 1'b0, st_r.ind};
                PSCR_ADDR_IRQST: st_nxt.rdata = {4'h0, st_r.ist};
                PSCR_ADDR_IRQMSK: st_nxt.rdata = {4'h0, st_r.msk};
                PSCR_ADDR_CMD: st_nxt.rdata = {7'h00, st_r.serial_bank};
                default: st_nxt.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= '0;
            // RL9 RL15 switch groups reset to zero
            st_r.fsw2 <= PSCR_FSW2_RST;
            st_r.blk <= PSCR_BLK_RST;
            st_r.msk <= PSCR_MSK_RST[3:0];
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata = st_r.rdata;
    assign stage_start = st_r.start;
    assign stage_operate = st_r.oper;
    assign start_indication = st_r.ind;
    assign out_of_service_display = st_r.oos;
    assign autoreclose_output_first = st_r.ar1;
    assign signal_output_third = st_r.ss3;
    assign autoreclose_output_third = st_r.ar3;
    assign setting_bank = st_r.bank;
    assign irq = st_r.irq;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_ar1_ss3;
        @(posedge core_clk) disable iff (!rst_b)
        autoreclose_output_first == signal_output_third;
    endproperty
    a_ar1_ss3: assert property (p_ar1_ss3) else $error("ar1 and ss3 differ"); // RL7

    property p_hp_oos;
        @(posedge core_clk) disable iff (!rst_b)
        $past(st_r.fsw2[PSCR_F_HP_OOS]) |-> !stage_start[PSCR_STG_HP];
    endproperty
    a_hp_oos: assert property (p_hp_oos) else $error("hp start while oos"); // RL3

    property p_he_oos;
        @(posedge core_clk) disable iff (!rst_b)
        $past(st_r.fsw2[PSCR_F_HE_OOS]) |-> !stage_operate[PSCR_STG_HE];
    endproperty
    a_he_oos: assert property (p_he_oos) else $error("he operate while oos"); // RL4

    property p_ar1_route;
        @(posedge core_clk) disable iff (!rst_b)
        $past(st_r.fsw2[PSCR_F_AR1_HP]) |-> autoreclose_output_first == stage_start[PSCR_STG_HP];
    endproperty
    a_ar1_route: assert property (p_ar1_route) else $error("ar1 route wrong"); // RL5

    property p_ar3_route;
        @(posedge core_clk) disable iff (!rst_b)
        autoreclose_output_third == ($past(st_r.fsw2[PSCR_F_AR3_HE]) ?
            stage_start[PSCR_STG_HE] : stage_start[PSCR_STG_LE]);
    endproperty
    a_ar3_route: assert property (p_ar3_route) else $error("ar3 route wrong"); // RL8

    property p_unblocked;
        @(posedge core_clk) disable iff (!rst_b)
        ($past(st_r.blk[3:0]) == 4'h0 && $past(sr_start) == 4'hF && $past(enable_v) == 4'hF)
            |-> stage_start == 4'hF;
    endproperty
    a_unblocked: assert property (p_unblocked) else $error("stage blocked"); // RL11

    property p_bank_ext;
        @(posedge core_clk) disable iff (!rst_b)
        $past(st_r.blk[PSCR_B_BANK_EXT]) |-> setting_bank == $past(sr_blk);
    endproperty
    a_bank_ext: assert property (p_bank_ext) else $error("bank not from input"); // RL13

    property p_auto_ind;
        @(posedge core_clk) disable iff (!rst_b)
        !$past(st_r.fsw2[PSCR_STG_LP]) |-> start_indication[0] == stage_start[0];
    endproperty
    a_auto_ind: assert property (p_auto_ind) else $error("auto indication wrong"); // RL1
endmodule : pscr_top

// ==== test/pscr_partner.sv ====
// Purpose: far-side model driving stage, control and alternate pins
// Assumes: bench names wanted levels; model applies them after an edge
// Notes: plain levels, no protocol on these pins
`timescale 1ns/10ps
module pscr_partner (
    input wire logic core_clk, // clock
    input wire logic [10:0] want, // {rst, alt, blk, oper, start}
    output logic [3:0] stage_start_raw, // stage starts
    output logic [3:0] stage_operate_raw, // stage operates
    output logic external_block_input, // block or control level
    output logic signal_output_third_alt, // other source for ss3 path
    output logic indication_reset // manual indicator reset
);
    initial begin
        {indication_reset, signal_output_third_alt, external_block_input} = 3'h0;
        {stage_operate_raw, stage_start_raw} = 8'h00;
    end
    always @(posedge core_clk) begin
        {indication_reset, signal_output_third_alt, external_block_input, stage_operate_raw,
            stage_start_raw} <= want;
    end
endmodule : pscr_partner

// ==== test/testbench.sv ====
// Purpose: self-checking bench for stage config and routing
// Assumes: pin levels settle within six cycles
// Notes: expectations queued by the driver, compared by a monitor
`timescale 1ns/10ps
module testbench;
    import pscr_pkg::*;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, f = 8'h00, b = 8'h00;
    logic reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0, look = 1'b0, cb = 1'b0, irq_e = 1'b0;
    logic [10:0] want = 11'h000;
    logic [3:0] stage_start_raw, stage_operate_raw, stage_start, stage_operate, start_indication;
    logic [3:0] ind_e = 4'h0;
    logic [7:0] pb = 8'h00;
    logic external_block_input, indication_reset, signal_output_third_alt, irq, setting_bank;
    logic [1:0] out_of_service_display;
    logic autoreclose_output_first, signal_output_third, autoreclose_output_third;
    logic [31:0] seed = 32'h0000001E;
    logic [18:0] rq[$], oq[$];
    int failures = 0, num_checks = 0;

    always #5 core_clk = ~core_clk;
    pscr_top dut (.*);
    pscr_partner mdl (.*);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    task automatic chk(input string nm, input logic [18:0] seen, input logic [18:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic summarize();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : summarize
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        @(posedge core_clk);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        rq.push_back({11'h000, exp});
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(posedge core_clk);
    endtask : rd
    // drive pins, then note the outputs the switch settings imply
    task automatic step(input logic [3:0] s, input logic [3:0] o, input logic bi, input logic al);
        logic [3:0] g;
        logic [3:0] go;
        logic ar1;
        logic [3:0] en;
        logic [3:0] live1;
        logic [3:0] live2;
        // old pins seen under new switches while the writes land
        en = ~{f[5], 1'b0, f[4], 1'b0};
        live1 = want[3:0] & en & ~(pb[3:0] & {4{want[8]}});
        live2 = want[3:0] & en & ~(b[3:0] & {4{want[8]}});
        want <= {want[10], al, bi, o, s};
        repeat (6) @(posedge core_clk);
        g = s & ~{f[5], 1'b0, f[4], 1'b0} & ~(b[3:0] & {4{bi}});
        go = o & ~{f[5], 1'b0, f[4], 1'b0} & ~(b[3:0] & {4{bi}});
        ind_e = ((ind_e | live1 | live2) & f[3:0]) | g;
        pb = b;
        ar1 = f[6] ? g[1] : al;
        oq.push_back({b[4] ? bi : cb, f[5], f[4], ar1, ar1, f[7] ? g[3] : g[2], g, go, ind_e,
            irq_e});
        look <= 1'b1;
        @(posedge core_clk);
        look <= 1'b0;
    endtask : step

    // ------------------------------------------------------------
    // monitor
    // ------------------------------------------------------------
    always @(posedge core_clk) begin
        if (rd_d) begin
            chk("reg_rdata", {11'h000, reg_rdata}, rq.pop_front());
        end
        rd_d <= reg_rd;
        if (look) begin
            chk("outputs", {setting_bank, out_of_service_display, autoreclose_output_first,
                signal_output_third, autoreclose_output_third, stage_start, stage_operate,
                start_indication, irq}, oq.pop_front());
        end
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        failures++;
        summarize();
    end

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(posedge core_clk);
        rst_b <= 1'b1;
        rd(PSCR_ADDR_FSW2, PSCR_FSW2_RST);
        rd(PSCR_ADDR_BLK, PSCR_BLK_RST);
        rd(PSCR_ADDR_IRQMSK, PSCR_MSK_RST);
        rd(8'h07, 8'h00);
        wr(PSCR_ADDR_IRQMSK, 8'h00);
        for (int i = 0; i < 30; i++) begin
            f = 8'(rnd());
            b = 8'(rnd());
            wr(PSCR_ADDR_FSW2, f);
            wr(PSCR_ADDR_BLK, b);
            step(4'(rnd()), 4'(rnd()), 1'(rnd()), 1'(rnd()));
        end
        f = 8'h00;
        b = 8'h00;
        wr(PSCR_ADDR_FSW2, f);
        wr(PSCR_ADDR_BLK, b);
        step(4'hF, 4'hF, 1'b1, 1'b0);
        cb = 1'b1;
        wr(PSCR_ADDR_CMD, 8'h01);
        step(4'h0, 4'h0, 1'b0, 1'b0);
        step(4'h0, 4'h0, 1'b1, 1'b0);
        b = 8'h10;
        wr(PSCR_ADDR_BLK, b);
        step(4'h0, 4'h0, 1'b0, 1'b0);
        step(4'h0, 4'h0, 1'b1, 1'b1);
        cb = 1'b0;
        b = 8'h00;
        wr(PSCR_ADDR_CMD, 8'h00);
        wr(PSCR_ADDR_BLK, b);
        f = 8'h01;
        wr(PSCR_ADDR_FSW2, f);
        step(4'h5, 4'h0, 1'b0, 1'b0);
        step(4'h0, 4'h0, 1'b0, 1'b0);
        rd(PSCR_ADDR_STAT, 8'h01);
        wr(PSCR_ADDR_CMD, 8'h02);
        ind_e = 4'h0;
        step(4'h0, 4'h0, 1'b0, 1'b0);
        step(4'h1, 4'h0, 1'b0, 1'b0);
        step(4'h0, 4'h0, 1'b0, 1'b0);
        want[10] <= 1'b1;
        @(posedge core_clk);
        ind_e = 4'h0;
        step(4'h0, 4'h0, 1'b0, 1'b0);
        want[10] <= 1'b0;
        // sticky status, mask and level interrupt
        f = 8'h00;
        wr(PSCR_ADDR_FSW2, f);
        wr(PSCR_ADDR_IRQST, 8'hFF);
        step(4'h1, 4'h0, 1'b0, 1'b0);
        rd(PSCR_ADDR_IRQST, 8'h01);
        wr(PSCR_ADDR_IRQMSK, 8'h01);
        irq_e = 1'b1;
        step(4'h1, 4'h0, 1'b0, 1'b0);
        wr(PSCR_ADDR_IRQST, 8'h01);
        irq_e = 1'b0;
        step(4'h1, 4'h0, 1'b0, 1'b0);
        rd(PSCR_ADDR_IRQST, 8'h00);
        repeat (3) @(posedge core_clk);
        summarize();
    end
endmodule : testbench
